// [rtl/cbs_pkg.sv]
// Constants, types and opcode encodings for the branch, skip and bit-operation core slice.
// Assumes the surrounding core decodes words into the opcode set below.
// Function
// - Bit set ORs register with K; bit clear ANDs with 0xFF minus K; Z,N,V.
// - Test ANDs register with itself; clear XORs itself; set loads 0xFF, flags kept.
// - Relative jump loads PC+k+1; pointer jump loads Z; two cycles, flags kept.
// - Relative call pushes return address, loads PC+k+1, three cycles.
// - Pointer call pushes return address, loads Z, three cycles, flags kept.
// - Compare-skip-equal skips next word(s) when registers equal; 1/2/3 cycles.
// - Compares subtract only for Z,N,V,C,H; no register written; one cycle.
// - Register bit-test skips on bit clear or set; 1/2/3 cycles.
// - I/O bit-test skips on bit clear or set; 1/2/3 cycles, flags kept.
// - Flag branches test status bit s, taken loads PC+k+1; 1 or 2 cycles.
// - Carry and zero branches use same taken timing.
// - Signed ge taken when N xor V is 0; less when 1.
// - Half-carry branches taken on H set or clear.
// - T branches taken on T set or clear.
// - Overflow branches taken on V set or clear, flags kept.
// - Interrupt branches taken on I set or clear.
// - I/O bit set/clear write back the whole io_val byte with bit b changed; two cycles, no flags.
package cbs_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 10;
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic [7:0] ONE = 8'h01;
    // Status bit positions.
    localparam int FC = 0;
    localparam int FZ = 1;
    localparam int FN = 2;
    localparam int FV = 3;
    localparam int FS = 4;
    localparam int FH = 5;
    localparam int FT = 6;
    localparam int FI = 7;
    localparam logic [2:0] CYC_JUMP = 3'h2;
    localparam logic [2:0] CYC_CALL = 3'h3;
    localparam logic [2:0] CYC_RET = 3'h4;
    localparam logic [2:0] CYC_IOBIT = 3'h2;
    localparam logic [2:0] CYC_ONE = 3'h1;

    typedef enum logic [4:0] {
        OP_OR_MASK = 5'h00, OP_AND_NOT_MASK = 5'h01, OP_INC = 5'h02, OP_DEC = 5'h03,
        OP_SELF_AND_TEST = 5'h04, OP_ZERO_REGISTER = 5'h05, OP_LOAD_ALL_ONES = 5'h06,
        OP_RELATIVE_JUMP = 5'h07, OP_POINTER_JUMP = 5'h08, OP_RELATIVE_CALL = 5'h09,
        OP_POINTER_CALL = 5'h0a, OP_POP_PC = 5'h0b, OP_END_OF_HANDLER = 5'h0c,
        OP_COMPARE_SKIP_EQUAL = 5'h0d, OP_COMPARE_REGS = 5'h0e, OP_COMPARE_REGS_CARRY = 5'h0f,
        OP_COMPARE_IMMEDIATE = 5'h10, OP_SKIP_REG_BIT_CLEAR = 5'h11,
        OP_SKIP_REG_BIT_SET = 5'h12, OP_SKIP_IO_BIT_CLEAR = 5'h13, OP_SKIP_IO_BIT_SET = 5'h14,
        OP_BRANCH_FLAG_SET = 5'h15, OP_BRANCH_FLAG_CLEAR = 5'h16, OP_SET_IO_BIT = 5'h17,
        OP_CLEAR_IO_BIT = 5'h18, OP_SHIFT_LEFT_LOGICAL = 5'h19, OP_SHIFT_RIGHT_LOGICAL = 5'h1a,
        OP_NOP = 5'h1f
    } cbs_op_t;

    typedef struct packed {
        cbs_op_t op;
        logic [7:0] rd;
        logic [7:0] rr;
        logic [7:0] k;
        logic [2:0] bsel;
        logic [15:0] zptr;
        logic [7:0] io_val;
        logic next_is_two_word;
    } cbs_req_t;

    typedef struct packed {
        logic [7:0] value;
        logic reg_write;
        logic io_write;
        logic push_pc;
        logic pop_pc;
    } cbs_res_t;
endpackage

// [rtl/cbs_alu.sv]
// Combinational ALU for the bit, increment, compare and shift group.
// Assumes operands arrive from the register file on the same clock.
`timescale 1ns/10ps
`default_nettype none
module cbs_alu (
    input wire cbs_pkg::cbs_op_t i_op,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic [7:0] i_flags,
    output logic [7:0] o_result,
    output logic [7:0] o_flags,
    output logic o_write
);
    logic [8:0] diff;
    logic [4:0] hdiff;
    logic cin;
    logic [7:0] r;
    logic [7:0] f;
    always_comb begin
        r = i_a;
        f = i_flags;
        o_write = 1'b1;
        cin = 1'b0;
        diff = 9'h000;
        hdiff = 5'h00;
        unique case (i_op)
            cbs_pkg::OP_OR_MASK: r = i_a | i_b;
            cbs_pkg::OP_AND_NOT_MASK: r = i_a & (cbs_pkg::ALL_ONES - i_b);
            cbs_pkg::OP_INC: r = i_a + cbs_pkg::ONE;
            cbs_pkg::OP_DEC: r = i_a - cbs_pkg::ONE;
            cbs_pkg::OP_SELF_AND_TEST: begin
                r = i_a & i_a;
                o_write = 1'b0;
            end
            cbs_pkg::OP_ZERO_REGISTER: r = i_a ^ i_a;
            cbs_pkg::OP_LOAD_ALL_ONES: r = cbs_pkg::ALL_ONES;
            cbs_pkg::OP_SHIFT_LEFT_LOGICAL: r = {i_a[6:0], 1'b0};
            cbs_pkg::OP_SHIFT_RIGHT_LOGICAL: r = {1'b0, i_a[7:1]};
            cbs_pkg::OP_COMPARE_REGS, cbs_pkg::OP_COMPARE_REGS_CARRY,
            cbs_pkg::OP_COMPARE_IMMEDIATE: begin
                cin = (i_op == cbs_pkg::OP_COMPARE_REGS_CARRY) & i_flags[cbs_pkg::FC];
                diff = {1'b0, i_a} - {1'b0, i_b} - {8'h00, cin};
                hdiff = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]} - {4'h0, cin};
                r = diff[7:0];
                o_write = 1'b0;
            end
            default: o_write = 1'b0;
        endcase
        unique case (i_op)
            cbs_pkg::OP_OR_MASK, cbs_pkg::OP_AND_NOT_MASK, cbs_pkg::OP_SELF_AND_TEST,
            cbs_pkg::OP_ZERO_REGISTER: begin
                f[cbs_pkg::FV] = 1'b0;
                f[cbs_pkg::FN] = r[7];
                f[cbs_pkg::FZ] = (r == 8'h00);
                f[cbs_pkg::FS] = r[7];
            end
            cbs_pkg::OP_INC, cbs_pkg::OP_DEC: begin
                f[cbs_pkg::FV] = (i_op == cbs_pkg::OP_INC) ? (i_a == 8'h7f) : (i_a == 8'h80);
                f[cbs_pkg::FN] = r[7];
                f[cbs_pkg::FZ] = (r == 8'h00);
                f[cbs_pkg::FS] = r[7] ^ f[cbs_pkg::FV];
            end
            cbs_pkg::OP_SHIFT_LEFT_LOGICAL, cbs_pkg::OP_SHIFT_RIGHT_LOGICAL: begin
                f[cbs_pkg::FC] = (i_op == cbs_pkg::OP_SHIFT_LEFT_LOGICAL) ? i_a[7] : i_a[0];
                f[cbs_pkg::FN] = r[7];
                f[cbs_pkg::FZ] = (r == 8'h00);
                f[cbs_pkg::FV] = r[7] ^ f[cbs_pkg::FC];
                f[cbs_pkg::FS] = r[7] ^ f[cbs_pkg::FV];
            end
            cbs_pkg::OP_COMPARE_REGS, cbs_pkg::OP_COMPARE_REGS_CARRY,
            cbs_pkg::OP_COMPARE_IMMEDIATE: begin
                f[cbs_pkg::FC] = diff[8];
                f[cbs_pkg::FH] = hdiff[4];
                f[cbs_pkg::FN] = r[7];
                f[cbs_pkg::FV] = (i_a[7] & ~i_b[7] & ~r[7]) | (~i_a[7] & i_b[7] & r[7]);
                f[cbs_pkg::FS] = r[7] ^ f[cbs_pkg::FV];
                // The carry form keeps Z low unless it was already set, for multi-byte compares.
                f[cbs_pkg::FZ] = (r == 8'h00) &
                    ((i_op != cbs_pkg::OP_COMPARE_REGS_CARRY) | i_flags[cbs_pkg::FZ]);
            end
            default: f = i_flags;
        endcase
        o_result = r;
        o_flags = f;
    end
endmodule
`default_nettype wire

// [rtl/cbs_core.sv]
// Execution slice of an 8-bit core: bit ops, compares, skips, branches, calls, returns.
// Assumes the fetch unit holds i_req stable while o_busy is high and gives i_pc as
// the address of the word after the current one.
`timescale 1ns/10ps
`default_nettype none
module cbs_core #(
    parameter int PC_W = cbs_pkg::PC_W
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_valid,
    input wire cbs_pkg::cbs_req_t i_req,
    input wire logic [PC_W-1:0] i_pc,
    input wire logic [PC_W-1:0] i_stack_pc,
    output logic o_busy,
    output logic o_done,
    output cbs_pkg::cbs_res_t o_res,
    output logic [PC_W-1:0] o_next_pc,
    output logic [PC_W-1:0] o_return_pc,
    output logic [7:0] o_flag_register
);
    // The sign-extended offset is sixteen bits wide, so wider counters cannot be served.
    if (PC_W < 2 || PC_W > 16) begin : g_pc_w_check
        $error("PC_W out of range");
    end

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } cbs_state_t;

    cbs_state_t state;
    logic [2:0] cnt;
    logic [7:0] flag_register;
    logic [7:0] alu_res;
    logic [7:0] alu_flags;
    logic alu_write;
    logic [7:0] bmask;
    logic [PC_W-1:0] rel_target;
    logic [PC_W-1:0] skip_target;
    logic sel_flag;
    logic flag_cond;
    logic reg_bit;
    logic io_bit;
    logic skip;
    logic is_branch;
    logic taken;
    logic [2:0] cycles;
    logic [PC_W-1:0] next_pc;
    logic start;
    cbs_pkg::cbs_op_t op;

    function automatic logic [7:0] bit_mask(input logic [2:0] b);
        bit_mask = cbs_pkg::ONE << b;
    endfunction

    assign op = i_req.op;
    assign bmask = bit_mask(i_req.bsel);
    assign reg_bit = |(i_req.rr & bmask);
    assign io_bit = |(i_req.io_val & bmask);
    assign sel_flag = |(flag_register & bmask);
    assign rel_target = i_pc + PC_W'({{8{i_req.k[7]}}, i_req.k});
    assign skip_target = i_pc + (i_req.next_is_two_word ? PC_W'(2) : PC_W'(1));
    // Named flag branches are encoded as the flag-bit forms with s selecting C,Z,N,V,S,H,T,I.
    assign flag_cond = sel_flag;
    assign is_branch = (op == cbs_pkg::OP_BRANCH_FLAG_SET) ||
                       (op == cbs_pkg::OP_BRANCH_FLAG_CLEAR);
    assign skip = ((op == cbs_pkg::OP_COMPARE_SKIP_EQUAL) && (i_req.rd == i_req.rr)) ||
                  ((op == cbs_pkg::OP_SKIP_REG_BIT_CLEAR) && !reg_bit) ||
                  ((op == cbs_pkg::OP_SKIP_REG_BIT_SET) && reg_bit) ||
                  ((op == cbs_pkg::OP_SKIP_IO_BIT_CLEAR) && !io_bit) ||
                  ((op == cbs_pkg::OP_SKIP_IO_BIT_SET) && io_bit);
    assign taken = ((op == cbs_pkg::OP_BRANCH_FLAG_SET) && flag_cond) ||
                   ((op == cbs_pkg::OP_BRANCH_FLAG_CLEAR) && !flag_cond);

    cbs_alu u_alu (
        .i_op(op),
        .i_a(i_req.rd),
        .i_b((op == cbs_pkg::OP_COMPARE_IMMEDIATE || op == cbs_pkg::OP_OR_MASK ||
              op == cbs_pkg::OP_AND_NOT_MASK) ? i_req.k : i_req.rr),
        .i_flags(flag_register),
        .o_result(alu_res),
        .o_flags(alu_flags),
        .o_write(alu_write)
    );

    always_comb begin
        next_pc = i_pc;
        cycles = cbs_pkg::CYC_ONE;
        unique case (op)
            cbs_pkg::OP_RELATIVE_JUMP: begin
                next_pc = rel_target;
                cycles = cbs_pkg::CYC_JUMP;
            end
            cbs_pkg::OP_POINTER_JUMP: begin
                next_pc = i_req.zptr[PC_W-1:0];
                cycles = cbs_pkg::CYC_JUMP;
            end
            cbs_pkg::OP_RELATIVE_CALL: begin
                next_pc = rel_target;
                cycles = cbs_pkg::CYC_CALL;
            end
            cbs_pkg::OP_POINTER_CALL: begin
                next_pc = i_req.zptr[PC_W-1:0];
                cycles = cbs_pkg::CYC_CALL;
            end
            cbs_pkg::OP_POP_PC, cbs_pkg::OP_END_OF_HANDLER: begin
                next_pc = i_stack_pc;
                cycles = cbs_pkg::CYC_RET;
            end
            cbs_pkg::OP_SET_IO_BIT, cbs_pkg::OP_CLEAR_IO_BIT: cycles = cbs_pkg::CYC_IOBIT;
            default: begin
                if (skip) begin
                    next_pc = skip_target;
                    cycles = i_req.next_is_two_word ? cbs_pkg::CYC_CALL : cbs_pkg::CYC_JUMP;
                end else if (is_branch && taken) begin
                    next_pc = rel_target;
                    cycles = cbs_pkg::CYC_JUMP;
                end
            end
        endcase
    end

    assign start = i_valid && (state == ST_IDLE);
    assign o_busy = (state == ST_WAIT) || (start && cycles != cbs_pkg::CYC_ONE);
    assign o_flag_register = flag_register;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state <= ST_IDLE;
            cnt <= 3'h0;
        end else if (start && cycles != cbs_pkg::CYC_ONE) begin
            state <= ST_WAIT;
            cnt <= cycles - cbs_pkg::CYC_ONE - cbs_pkg::CYC_ONE;
        end else if (state == ST_WAIT) begin
            if (cnt == 3'h0) begin
                state <= ST_IDLE;
            end
            cnt <= cnt - 3'h1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            flag_register <= 8'h00;
        end else if (start) begin
            if (op == cbs_pkg::OP_END_OF_HANDLER) begin
                flag_register[cbs_pkg::FI] <= 1'b1;
            end else begin
                flag_register <= alu_flags;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_done <= 1'b0;
            o_res <= '0;
            o_next_pc <= '0;
            o_return_pc <= '0;
        end else begin
            o_done <= 1'b0;
            if (start) begin
                o_next_pc <= next_pc;
                o_return_pc <= i_pc;
                o_res.reg_write <= alu_write;
                o_res.io_write <= (op == cbs_pkg::OP_SET_IO_BIT) ||
                                  (op == cbs_pkg::OP_CLEAR_IO_BIT);
                o_res.push_pc <= (op == cbs_pkg::OP_RELATIVE_CALL) ||
                                 (op == cbs_pkg::OP_POINTER_CALL);
                o_res.pop_pc <= (op == cbs_pkg::OP_POP_PC) || (op == cbs_pkg::OP_END_OF_HANDLER);
                // The whole byte is written back from io_val, so other status bits that read one are also written one.
                if (op == cbs_pkg::OP_SET_IO_BIT) begin
                    o_res.value <= i_req.io_val | bmask;
                end else if (op == cbs_pkg::OP_CLEAR_IO_BIT) begin
                    o_res.value <= i_req.io_val & ~bmask;
                end else begin
                    o_res.value <= alu_res;
                end
            end
            if ((start && cycles == cbs_pkg::CYC_ONE) ||
                (state == ST_WAIT && cnt == 3'h0)) begin
                o_done <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/cbs_assertions.sv]
// Checker for the execution slice: cycle counts, targets and flags at the ports.
// Assumes requests are held until completion and reset is synchronous.
`timescale 1ns/10ps
`default_nettype none
module cbs_assertions #(
    parameter int PC_W = 10
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_valid,
    input wire cbs_pkg::cbs_req_t i_req,
    input wire logic [PC_W-1:0] i_pc,
    input wire logic o_done,
    input wire cbs_pkg::cbs_res_t o_res,
    input wire logic [PC_W-1:0] o_next_pc,
    input wire logic [7:0] o_flag_register
);
    // The slice is free when idle or finishing, so a request seen then is taken.
    logic idle;
    logic take;
    logic [PC_W-1:0] rel;
    cbs_pkg::cbs_op_t op;
    assign take = i_valid && (idle || o_done);
    assign op = i_req.op;
    assign rel = i_pc + PC_W'($signed(i_req.k));
    always_ff @(posedge i_clk_sys) begin
        idle <= i_reset || ((idle || o_done) && !i_valid);
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    jump_two_a: assert property (
        take && op == cbs_pkg::OP_RELATIVE_JUMP |=> !o_done && o_next_pc == $past(rel) ##1 o_done
    ) else $error("relative jump wrong");
    call_three_a: assert property (
        take && op inside {cbs_pkg::OP_RELATIVE_CALL, cbs_pkg::OP_POINTER_CALL}
        |=> (!o_done)[*2] ##1 (o_done && o_res.push_pc)) else $error("call timing wrong");
    return_four_a: assert property (
        take && op inside {cbs_pkg::OP_POP_PC, cbs_pkg::OP_END_OF_HANDLER}
        |=> (!o_done)[*3] ##1 (o_done && o_res.pop_pc)) else $error("return timing wrong");
    io_bit_a: assert property (
        take && op == cbs_pkg::OP_SET_IO_BIT |-> ##2 o_done && o_res.io_write
        && o_res.value == ($past(i_req.io_val, 2) | (8'h01 << $past(i_req.bsel, 2)))
    ) else $error("io bit set wrong");
    branch_taken_a: assert property (
        take && op == cbs_pkg::OP_BRANCH_FLAG_SET && o_flag_register[i_req.bsel]
        |=> !o_done && o_next_pc == $past(rel) ##1 o_done) else $error("branch taken wrong");
    branch_not_a: assert property (
        take && op == cbs_pkg::OP_BRANCH_FLAG_CLEAR && o_flag_register[i_req.bsel]
        |=> o_done && o_next_pc == $past(i_pc)) else $error("untaken branch wrong");
    compare_nowr_a: assert property (
        take && op inside {cbs_pkg::OP_COMPARE_REGS, cbs_pkg::OP_COMPARE_IMMEDIATE}
        |=> o_done && !o_res.reg_write) else $error("compare wrote a register");
    ones_keep_a: assert property (
        take && op == cbs_pkg::OP_LOAD_ALL_ONES |=> o_done && o_res.value == 8'hff
        && $stable(o_flag_register)) else $error("load ones wrong");
    cover property (take && op == cbs_pkg::OP_RELATIVE_CALL);
    cover property (take && op == cbs_pkg::OP_BRANCH_FLAG_SET ##2 o_done);
    cover property (take && op == cbs_pkg::OP_COMPARE_SKIP_EQUAL && i_req.next_is_two_word);
endmodule
bind cbs_core cbs_assertions #(.PC_W(PC_W)) u_chk (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_valid(i_valid), .i_req(i_req),
    .i_pc(i_pc), .o_done(o_done), .o_res(o_res), .o_next_pc(o_next_pc),
    .o_flag_register(o_flag_register));
`default_nettype wire

// [tb/cbs_far_side.sv]
// Far side of the slice: return stack and one bit-addressable I/O byte.
// Assumes writes and pushes are applied on the completion pulse.
`timescale 1ns/10ps
`default_nettype none
module cbs_far_side #(
    parameter int PC_W = 10
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_done,
    input wire cbs_pkg::cbs_res_t i_res,
    input wire logic [PC_W-1:0] i_push_pc,
    output logic [PC_W-1:0] o_stack_pc,
    output logic [7:0] o_io
);
    // Only four levels deep; deeper nesting would wrap silently.
    logic [PC_W-1:0] stack [4];
    logic [1:0] sp;
    assign o_stack_pc = stack[sp - 2'h1];
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            sp <= 2'h0;
            o_io <= 8'h5a;
        end else if (i_done) begin
            if (i_res.push_pc) stack[sp] <= i_push_pc;
            if (i_res.push_pc) sp <= sp + 2'h1;
            if (i_res.pop_pc) sp <= sp - 2'h1;
            if (i_res.io_write) o_io <= i_res.value;
        end
    end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the execution slice.
// Assumes the far-side model starts its I/O byte at 8'h5a.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic valid = 1'b0;
    logic [9:0] pc = 10'h100;
    cbs_pkg::cbs_req_t req = '0;
    cbs_pkg::cbs_req_t req_in;
    cbs_pkg::cbs_res_t res;
    logic busy, done;
    logic [9:0] next_pc, return_pc, stack_pc;
    logic [7:0] flags, io, f;
    int fail_count = 0;
    int tests_run = 0;
    always #25 clk = ~clk;
    always_comb begin
        req_in = req;
        req_in.io_val = io;
    end
    cbs_core #(.PC_W(10)) DUT (.i_clk_sys(clk), .i_reset(rst), .i_valid(valid),
        .i_req(req_in), .i_pc(pc), .i_stack_pc(stack_pc), .o_busy(busy), .o_done(done),
        .o_res(res), .o_next_pc(next_pc), .o_return_pc(return_pc), .o_flag_register(flags));
    cbs_far_side #(.PC_W(10)) far (.i_clk_sys(clk), .i_reset(rst), .i_done(done),
        .i_res(res), .i_push_pc(return_pc), .o_stack_pc(stack_pc), .o_io(io));
    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", w, e, g);
        end
    endtask
    // One idle cycle before each request keeps valid from being set twice in a step.
    task automatic ex(input cbs_pkg::cbs_op_t op, input logic [7:0] rd, input logic [7:0] rr,
            input logic [7:0] k, input logic [2:0] b, input logic two, input int nc);
        int n;
        n = 0;
        @(negedge clk);
        req = '{op, rd, rr, k, b, 16'h0123, 8'h00, two};
        valid = 1'b1;
        do begin
            @(negedge clk);
            n++;
            // Only multi-cycle work keeps the slice busy once the request is taken.
            if (n == 1) chk("busy", 16'(nc > 1), 16'(busy));
        end while (done !== 1'b1 && n < 8);
        valid = 1'b0;
        chk("cycles", 16'(nc), 16'(n));
    endtask
    task automatic alu(input cbs_pkg::cbs_op_t op, input logic [7:0] rd, input logic [7:0] k,
            input logic [7:0] v, input logic [3:0] fl, input logic wr);
        ex(op, rd, rd, k, 3'h0, 1'b0, 1);
        chk("write", 16'(wr), 16'(res.reg_write));
        if (wr) chk("value", 16'(v), 16'(res.value));
        chk("flags", 16'(fl), 16'(flags[3:0]));
    endtask
    task automatic skp(input cbs_pkg::cbs_op_t op, input logic [7:0] rr, input logic [2:0] b,
            input logic two, input int nc);
        ex(op, 8'h33, rr, 8'h00, b, two, nc);
        chk("skip pc", 16'(pc + 10'(nc - 1)), 16'(next_pc));
    endtask
    task automatic brs(input logic [7:0] fe);
        chk("cmp flags", 16'(fe), 16'(flags));
        chk("cmp write", 16'h0000, 16'(res.reg_write));
        for (int s = 0; s < 8; s++) begin
            ex(cbs_pkg::OP_BRANCH_FLAG_SET, 0, 0, 8'h10, 3'(s), 0, fe[s] ? 2 : 1);
            chk("set br", fe[s] ? 16'h0110 : 16'h0100, 16'(next_pc));
            ex(cbs_pkg::OP_BRANCH_FLAG_CLEAR, 0, 0, 8'h10, 3'(s), 0, fe[s] ? 1 : 2);
            chk("clear br", fe[s] ? 16'h0100 : 16'h0110, 16'(next_pc));
        end
        chk("br flags", 16'(fe), 16'(flags));
    endtask
    task automatic finish_test();
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        chk("reset flags", 16'h0000, 16'(flags));
        alu(cbs_pkg::OP_SHIFT_LEFT_LOGICAL, 8'h81, 8'h00, 8'h02, 4'h9, 1'b1);
        alu(cbs_pkg::OP_INC, 8'h7f, 8'h00, 8'h80, 4'hd, 1'b1);
        alu(cbs_pkg::OP_DEC, 8'h80, 8'h00, 8'h7f, 4'h9, 1'b1);
        alu(cbs_pkg::OP_OR_MASK, 8'h96, 8'h41, 8'hd7, 4'h5, 1'b1);
        alu(cbs_pkg::OP_AND_NOT_MASK, 8'h96, 8'h06, 8'h90, 4'h5, 1'b1);
        alu(cbs_pkg::OP_SELF_AND_TEST, 8'h00, 8'h00, 8'h00, 4'h3, 1'b0);
        alu(cbs_pkg::OP_ZERO_REGISTER, 8'h96, 8'h00, 8'h00, 4'h3, 1'b1);
        alu(cbs_pkg::OP_SHIFT_RIGHT_LOGICAL, 8'h01, 8'h00, 8'h00, 4'hb, 1'b1);
        alu(cbs_pkg::OP_LOAD_ALL_ONES, 8'h00, 8'h00, 8'hff, 4'hb, 1'b1);
        $display("bits test ended");
        f = flags;
        ex(cbs_pkg::OP_RELATIVE_JUMP, 0, 0, 8'hfe, 0, 0, 2);
        chk("jump", 16'h00fe, 16'(next_pc));
        ex(cbs_pkg::OP_POINTER_JUMP, 0, 0, 0, 0, 0, 2);
        chk("pjump", 16'h0123, 16'(next_pc));
        ex(cbs_pkg::OP_RELATIVE_CALL, 0, 0, 8'h05, 0, 0, 3);
        chk("call", 16'h0105, 16'(next_pc));
        pc = 10'h200;
        ex(cbs_pkg::OP_POINTER_CALL, 0, 0, 0, 0, 0, 3);
        chk("pcall", 16'h0123, 16'(next_pc));
        chk("flags kept", 16'(f), 16'(flags));
        ex(cbs_pkg::OP_POP_PC, 0, 0, 0, 0, 0, 4);
        chk("return", 16'h0200, 16'(next_pc));
        ex(cbs_pkg::OP_END_OF_HANDLER, 0, 0, 0, 0, 0, 4);
        chk("handler return", 16'h0100, 16'(next_pc));
        chk("ie", 16'(f | 8'h80), 16'(flags));
        pc = 10'h100;
        $display("flow test ended");
        skp(cbs_pkg::OP_COMPARE_SKIP_EQUAL, 8'h33, 0, 0, 2);
        skp(cbs_pkg::OP_COMPARE_SKIP_EQUAL, 8'h33, 0, 1, 3);
        skp(cbs_pkg::OP_COMPARE_SKIP_EQUAL, 8'h34, 0, 1, 1);
        skp(cbs_pkg::OP_SKIP_REG_BIT_CLEAR, 8'h5a, 0, 0, 2);
        skp(cbs_pkg::OP_SKIP_REG_BIT_CLEAR, 8'h5a, 1, 1, 1);
        skp(cbs_pkg::OP_SKIP_REG_BIT_SET, 8'h5a, 1, 1, 3);
        skp(cbs_pkg::OP_SKIP_IO_BIT_CLEAR, 8'h00, 2, 0, 2);
        skp(cbs_pkg::OP_SKIP_IO_BIT_SET, 8'h00, 2, 0, 1);
        chk("skip flags", 16'(f | 8'h80), 16'(flags));
        ex(cbs_pkg::OP_COMPARE_REGS, 8'h10, 8'h20, 0, 0, 0, 1);
        brs(8'h95);
        ex(cbs_pkg::OP_COMPARE_IMMEDIATE, 8'h80, 0, 8'h01, 0, 0, 1);
        brs(8'hb8);
        ex(cbs_pkg::OP_COMPARE_REGS_CARRY, 8'h10, 8'h10, 0, 0, 0, 1);
        brs(8'h80);
        ex(cbs_pkg::OP_SET_IO_BIT, 0, 0, 0, 3'h7, 0, 2);
        chk("io set", 16'h00da, 16'(res.value));
        ex(cbs_pkg::OP_CLEAR_IO_BIT, 0, 0, 0, 3'h1, 0, 2);
        @(negedge clk);
        chk("io clear", 16'h00d8, 16'(io));
        chk("io flags", 16'h0080, 16'(flags));
        $display("skip, branch and io tests ended");
        finish_test();
    end
    // About 200 cycles are needed; 2000 leaves margin for slow completions.
    initial begin
        #100000;
        fail_count++;
        $display("BAD watchdog expected finish seen timeout");
        finish_test();
    end
endmodule
`default_nettype wire
